// *** src/flash_poll_regs.svh ***
`ifndef FLASH_POLL_REGS_SVH
`define FLASH_POLL_REGS_SVH

// =====================================================================
// clock and bus timing
`define CLK_PERIOD_NS 25
`define T_ACC_NS 100
`define T_WP_NS 35
// two extra cycles cover the data synchroniser
`define RD_CYC ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 2)
`define WP_CYC ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// =====================================================================
// status bit positions on the data lines
`define BIT_POLL 7
`define BIT_OPTOG 6
`define BIT_LIMIT 5
`define BIT_TIMER 3
`define BIT_SECTOG 2
`define BIT_ABORT 1

// =====================================================================
// command words and unlock addresses
`define CMD_RESET 8'hF0
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define ADDR_UNLOCK1 24'h000555
`define ADDR_UNLOCK2 24'h0002AA

`endif

// *** src/flash_poll_pkg.sv ***
`default_nettype none
package flash_poll_pkg;

	// =================================================================
	// user orders and answers
	typedef enum logic [2:0] {
		OP_WRITE, OP_POLL, OP_SECTOR, OP_TIMER, OP_RESET, OP_ABORT_RESET
	} op_type;

	typedef enum logic [2:0] {
		ST_OK, ST_FAIL, ST_ABORT, ST_INFO, ST_CANCEL
	} status_type;

	typedef struct packed {
		op_type op;
		logic [23:0] addr;
		logic [7:0] data;
	} cmd_type;

	typedef struct packed {
		status_type status;
		logic [7:0] data;
		logic limit;
		logic timer;
		logic sec_tog;
		logic op_tog;
		logic ready;
	} result_type;

	// =================================================================
	// flash pin outputs
	typedef struct packed {
		logic [23:0] addr;
		logic [7:0] dq_out;
		logic dq_oe_n;
		logic ce_n;
		logic oe_n;
		logic we_n;
	} pins_type;

endpackage : flash_poll_pkg
`default_nettype wire

// *** src/flash_status_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flash_poll_regs.svh"

module flash_status_host (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// user side
	input wire logic cmd_valid,
	input wire flash_poll_pkg::cmd_type cmd,
	output var logic cmd_ready,
	input wire logic poll_cancel,
	output var logic done,
	output var flash_poll_pkg::result_type result,
	// flash pins
	output var flash_poll_pkg::pins_type pins,
	input wire logic [7:0] dq_in,
	input wire logic ready_busy_n_output
);
	import flash_poll_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_RSET, S_RD, S_WSET, S_WR, S_GAP, S_EVAL, S_DONE
	} state_type;

	// =================================================================
	// write sequence table
	function automatic logic [32:0] wr_step(input op_type op, input logic [1:0] idx,
			input logic [23:0] a, input logic [7:0] d);
		logic [32:0] r;
		r = {1'b1, a, d};
		if (op == OP_RESET) begin
			r = {1'b1, a, `CMD_RESET};
		end else if (op == OP_ABORT_RESET) begin
			case (idx)
				2'h0: r = {1'b0, `ADDR_UNLOCK1, `CMD_UNLOCK1};
				2'h1: r = {1'b0, `ADDR_UNLOCK2, `CMD_UNLOCK2};
				default: r = {1'b1, `ADDR_UNLOCK1, `CMD_RESET};
			endcase
		end
		return r;
	endfunction : wr_step

	// =================================================================
	// pin synchronisers
	logic [7:0] dq_s1_q, dq_s2_q;
	logic rb_s1_q, rb_s2_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dq_s1_q <= 8'h00;
			dq_s2_q <= 8'h00;
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
		end else begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
			rb_s1_q <= ready_busy_n_output;
			rb_s2_q <= rb_s1_q;
		end
	end

	// =================================================================
	// sequencer
	state_type state_q, gnext_q;
	op_type op_q, wop_q;
	logic [23:0] addr_q;
	logic [7:0] data_q, first_q, last_q;
	logic [3:0] cnt_q;
	logic [1:0] nrd_q, widx_q;
	logic rechk_q, array_q;
	logic [7:0] diff;
	logic [32:0] step;

	assign diff = first_q ^ last_q;
	assign step = wr_step(wop_q, widx_q, addr_q, data_q);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;
			gnext_q <= S_IDLE;
			op_q <= OP_WRITE;
			wop_q <= OP_WRITE;
			addr_q <= 24'h000000;
			data_q <= 8'h00;
			first_q <= 8'h00;
			last_q <= 8'h00;
			cnt_q <= 4'h0;
			nrd_q <= 2'h0;
			widx_q <= 2'h0;
			rechk_q <= 1'b0;
			array_q <= 1'b0;
			cmd_ready <= 1'b0;
			done <= 1'b0;
			result <= '0;
			pins <= '{addr: 24'h000000, dq_out: 8'h00, dq_oe_n: 1'b1,
				ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
		end else begin
			done <= 1'b0;
			case (state_q)
				S_IDLE: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						op_q <= cmd.op;
						wop_q <= cmd.op;
						addr_q <= cmd.addr;
						data_q <= cmd.data;
						widx_q <= 2'h0;
						nrd_q <= 2'h0;
						rechk_q <= 1'b0;
						array_q <= 1'b0;
						result <= '0;
						if (cmd.op == OP_WRITE || cmd.op == OP_RESET ||
								cmd.op == OP_ABORT_RESET) begin
							state_q <= S_WSET;
						end else begin
							state_q <= S_RSET;
						end
					end
				end
				S_RSET: begin
					// both strobes fall, so either style of device counts it
					pins.addr <= addr_q;
					pins.dq_oe_n <= 1'b1;
					pins.ce_n <= 1'b0;
					pins.oe_n <= 1'b0;
					cnt_q <= 4'h0;
					state_q <= S_RD;
				end
				S_RD: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'(`RD_CYC - 1)) begin
						last_q <= dq_s2_q;
						first_q <= last_q;
						if (nrd_q != 2'h3) begin
							nrd_q <= nrd_q + 2'h1;
						end
						pins.ce_n <= 1'b1;
						pins.oe_n <= 1'b1;
						gnext_q <= S_EVAL;
						state_q <= S_GAP;
					end
				end
				S_WSET: begin
					pins.addr <= step[31:8];
					pins.dq_out <= step[7:0];
					pins.dq_oe_n <= 1'b0;
					pins.ce_n <= 1'b0;
					pins.we_n <= 1'b0;
					cnt_q <= 4'h0;
					state_q <= S_WR;
				end
				S_WR: begin
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == 4'(`WP_CYC - 1)) begin
						pins.we_n <= 1'b1;
						pins.ce_n <= 1'b1;
						widx_q <= widx_q + 2'h1;
						gnext_q <= step[32] ? S_DONE : S_WSET;
						state_q <= S_GAP;
					end
				end
				S_GAP: begin
					// data held one cycle past the strobe for hold time
					pins.dq_oe_n <= 1'b1;
					state_q <= gnext_q;
				end
				S_EVAL: begin
					result.data <= last_q;
					result.limit <= last_q[`BIT_LIMIT];
					result.timer <= last_q[`BIT_TIMER];
					result.sec_tog <= diff[`BIT_SECTOG];
					result.op_tog <= diff[`BIT_OPTOG];
					if (poll_cancel) begin
						result.status <= ST_CANCEL;
						state_q <= S_DONE;
					end else if (nrd_q < 2'h2) begin
						state_q <= S_RSET;
					end else if (op_q != OP_POLL) begin
						// sector and timer reads follow a confirming double read;
						// timer read only on order, so fast erase sequences may skip it
						result.status <= ST_INFO;
						state_q <= S_DONE;
					end else if (array_q) begin
						result.status <= ST_OK;
						state_q <= S_DONE;
					end else if (!diff[`BIT_OPTOG]) begin
						array_q <= 1'b1;
						state_q <= S_RSET;
					end else if (last_q[`BIT_ABORT]) begin
						result.status <= ST_ABORT;
						wop_q <= OP_ABORT_RESET;
						widx_q <= 2'h0;
						state_q <= S_WSET;
					end else if (last_q[`BIT_LIMIT] && rechk_q) begin
						result.status <= ST_FAIL;
						wop_q <= OP_RESET;
						widx_q <= 2'h0;
						state_q <= S_WSET;
					end else begin
						// limit flag may rise as toggling stops, so look once more
						rechk_q <= rechk_q | last_q[`BIT_LIMIT];
						state_q <= S_RSET;
					end
				end
				S_DONE: begin
					if (op_q == OP_WRITE || op_q == OP_RESET || op_q == OP_ABORT_RESET) begin
						result.status <= ST_OK;
					end
					result.ready <= rb_s2_q;
					done <= 1'b1;
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

endmodule : flash_status_host
`default_nettype wire

// *** tb/flash_status_host_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// host side bus checks
module flash_status_host_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// user side
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic done,
	input wire flash_poll_pkg::result_type result,
	// flash pins
	input wire flash_poll_pkg::pins_type pins
);
	import flash_poll_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence rd_open_s; $fell(pins.oe_n); endsequence
	sequence rd_hold_s; !pins.oe_n [*6]; endsequence
	a_read_strobes: assert property (rd_open_s |-> !pins.ce_n && pins.dq_oe_n)
		else $error("read without select");
	a_read_length: assert property (rd_open_s |-> rd_hold_s)
		else $error("read strobe short");
	a_no_overlap: assert property (pins.oe_n || pins.we_n)
		else $error("strobes overlap");
	a_write_pulse: assert property ($fell(pins.we_n) |-> (!pins.we_n && !pins.dq_oe_n) [*2])
		else $error("write pulse short");
	a_done_pulse: assert property (done |=> !done)
		else $error("done too long");
	a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
		else $error("order not taken");
	a_fail_limit: assert property (done && result.status == ST_FAIL |-> result.limit && result.op_tog)
		else $error("fail without limit");
	a_idle_release: assert property (cmd_ready |-> pins.ce_n && pins.dq_oe_n)
		else $error("bus held while idle");
endmodule : flash_status_host_monitor
bind flash_status_host flash_status_host_monitor mon (.sys_clk, .rst, .cmd_valid, .cmd_ready,
	.done, .result, .pins);
`default_nettype wire

// *** tb/flash_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// behavioural flash status side
module flash_dev_model (
	// flash pins
	input wire flash_poll_pkg::pins_type pins,
	output logic [7:0] dq,
	output logic ready_busy_n_output
);
	import flash_poll_pkg::*;
	int busy = 0;
	int nw = 0;
	logic lim = 0, abt = 0, ers = 0, tmr = 0, t6 = 0, t2 = 0;
	logic [7:0] v = 8'h00;
	logic [31:0] wlast = 32'h00000000;
	wire rd = !pins.ce_n && !pins.oe_n;
	// released lines show the inverse so a late sample cannot pass
	assign dq = rd ? v : ~v;
	assign ready_busy_n_output = busy == 0;
	always @(posedge rd) begin
		if (busy > 0)
			v = {~ers, t6, lim, 1'b0, tmr, t2, abt, 1'b0};
		else
			v = 8'hA5;
	end
	always @(negedge rd) begin
		t2 = t2 ^ ers;
		if (busy > 0)
			t6 = ~t6;
		if (busy > 0 && !lim && !abt)
			busy = busy - 1;
	end
	// status is served from the rising write strobe on
	always @(posedge pins.we_n) begin
		nw = nw + 1;
		wlast = {pins.addr, pins.dq_out};
		if (tmr && !lim) begin
			// erase under way: only a suspend would be honoured
		end else if (pins.dq_out == 8'hF0) begin
			{busy, lim, abt, ers, tmr} = '0;
		end else if (ers) begin
			busy = 99; // a further sector restarts the window
		end
	end
endmodule : flash_dev_model
`default_nettype wire

// *** tb/flash_status_host_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====
// bench
module flash_status_host_tb_top;
	import flash_poll_pkg::*;
	typedef struct {op_type op; int b; logic l, a, e, t; status_type st; logic [3:0] f; int w;} row_type;
	logic sys_clk = 0;
	logic rst = 1;
	logic cmd_valid = 0;
	logic poll_cancel = 0;
	cmd_type cmd = '0;
	logic cmd_ready, done, ready_busy_n_output;
	result_type result;
	pins_type pins;
	logic [7:0] dq_in;
	int err_count = 0;
	int n_checks = 0;
	int n0;
	logic [31:0] wexp;
	row_type rows [9] = '{
		'{OP_POLL, 0, 0, 0, 0, 0, ST_OK, 4'h0, 0},
		'{OP_POLL, 3, 0, 0, 0, 0, ST_OK, 4'h0, 0},
		'{OP_POLL, 99, 1, 0, 0, 0, ST_FAIL, 4'h0, 1},
		'{OP_POLL, 99, 0, 1, 0, 0, ST_ABORT, 4'h0, 3},
		'{OP_SECTOR, 99, 0, 0, 1, 0, ST_INFO, 4'h3, 0},
		'{OP_TIMER, 99, 0, 0, 1, 1, ST_INFO, 4'h7, 0},
		'{OP_WRITE, 0, 0, 0, 0, 0, ST_OK, 4'h0, 1},
		'{OP_RESET, 0, 0, 0, 0, 0, ST_OK, 4'h0, 1},
		'{OP_ABORT_RESET, 0, 0, 0, 0, 0, ST_OK, 4'h0, 3}};
	always #12.5 sys_clk = ~sys_clk;
	flash_status_host dut (.sys_clk, .rst, .cmd_valid, .cmd, .cmd_ready, .poll_cancel, .done,
		.result, .pins, .dq_in, .ready_busy_n_output);
	flash_dev_model mdl (.pins, .dq(dq_in), .ready_busy_n_output);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	// entered at a falling edge with the host idle
	task automatic run(input op_type op);
		int i;
		n0 = mdl.nw;
		cmd_valid = 1;
		cmd = '{op, 24'h000123, 8'h3C};
		@(negedge sys_clk);
		cmd_valid = 0;
		for (i = 0; i < 4000 && done !== 1'b1; i++)
			@(negedge sys_clk);
		chk({31'h00000000, done}, 32'h00000001);
		for (i = 0; i < 400 && cmd_ready !== 1'b1; i++)
			@(negedge sys_clk);
	endtask : run
	initial begin
		#400000;
		err_count++;
		stop_test();
	end
	initial begin
		repeat (8) @(negedge sys_clk);
		rst = 0;
		repeat (2) @(negedge sys_clk);
		foreach (rows[k]) begin
			{mdl.busy, mdl.lim, mdl.abt, mdl.ers, mdl.tmr} = {rows[k].b, rows[k].l, rows[k].a,
				rows[k].e, rows[k].t};
			run(rows[k].op);
			chk(8'(result.status), 8'(rows[k].st));
			chk(8'(mdl.nw - n0), 8'(rows[k].w));
			wexp = {(rows[k].w == 3) ? 24'h000555 : 24'h000123, 8'hF0};
			if (rows[k].op == OP_WRITE)
				wexp[7:0] = 8'h3C;
			if (rows[k].w > 0)
				chk(mdl.wlast, wexp);
			if (rows[k].st == ST_INFO)
				chk({result.ready, result.timer, result.sec_tog, result.op_tog}, 8'(rows[k].f));
			if (rows[k].st == ST_OK && rows[k].op == OP_POLL)
				chk(result.data, 8'hA5);
		end
		mdl.busy = 99;
		poll_cancel = 1;
		run(OP_POLL);
		chk(8'(result.status), 8'(ST_CANCEL));
		poll_cancel = 0;
		cmd_valid = 1;
		@(negedge sys_clk);
		cmd_valid = 0;
		repeat (3) @(negedge sys_clk);
		rst = 1;
		@(negedge sys_clk);
		chk({cmd_ready, done, pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe_n}, 8'h0F);
		rst = 0;
		mdl.busy = 0;
		repeat (2) @(negedge sys_clk);
		run(OP_POLL);
		chk(result.data, 8'hA5);
		stop_test();
	end
endmodule : flash_status_host_tb_top
`default_nettype wire
